// File: verilog/cbst_regs.svh
// Register offsets, field positions, reset values and timing constants of the balance safety timer.
// Assumes a 125 MHz APB clock; offsets are byte addresses of aligned 32-bit words.
`ifndef CBST_REGS_SVH
`define CBST_REGS_SVH

`define CBST_OFF_BAL_CTRL 8'h00
`define CBST_OFF_TIMEOUT 8'h04
`define CBST_OFF_DEV_STAT 8'h08
`define CBST_OFF_FAULT_STAT 8'h0C
`define CBST_OFF_ADDR_CTRL 8'h10
`define CBST_OFF_RESET 8'h14
`define CBST_OFF_IRQ_STAT 8'h18
`define CBST_OFF_IRQ_MASK 8'h1C

`define CBST_BAL_UNIT_BIT 7
`define CBST_DEV_TIMER_BIT 0
`define CBST_DEV_LOCKOUT_BIT 1
`define CBST_DEV_ADDRV_BIT 2
`define CBST_FAULT_POR_BIT 0
`define CBST_IRQ_EXPIRE_BIT 0
`define CBST_IRQ_LOCKOUT_BIT 1
`define CBST_IRQ_POR_BIT 2

`define CBST_RESET_CODE 8'hA5
`define CBST_ADDR_MIN 6'h01
`define CBST_ADDR_MAX 6'h3E
`define CBST_BAL_RST 8'h00
`define CBST_TIMEOUT_RST 8'h00
`define CBST_MASK_RST 3'h0

`define CBST_CLK_KHZ 125000
`define CBST_SOFT_RST_US 300
`define CBST_LOCKOUT_US 100
`define CBST_SEC_PER_MIN 60
`define CBST_SOFT_RST_CYC (`CBST_SOFT_RST_US * `CBST_CLK_KHZ / 1000)
`define CBST_LOCKOUT_CYC (`CBST_LOCKOUT_US * `CBST_CLK_KHZ / 1000)
`define CBST_CYC_PER_SEC (`CBST_CLK_KHZ * 1000)

`endif

// File: verilog/cbst_pkg.sv
// Types shared by the balance safety timer modules.
// Assumes the constants header is included by the modules that need numbers.
package cbst_pkg;
  typedef enum logic {cbst_unit_sec, cbst_unit_min} cbst_unit_t;
  typedef enum logic [1:0] {cbst_idle, cbst_run, cbst_hold} cbst_state_t;
  typedef logic [5:0] cbst_bal_t;
endpackage

// File: verilog/cbst_tick_gen.sv
// Second and minute tick prescaler for the balance safety timer.
// Assumes a free-running pclk; restart realigns both ticks to a full period.
module cbst_tick_gen #(
  parameter int CYC_PER_SEC = 125000000,
  parameter int SEC_PER_MIN = 60
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic restart,
  output logic sec_tick,
  output logic min_tick
);
  import cbst_pkg::*;

  logic [31:0] pre_q;
  logic [7:0] sec_q;

  initial begin
    if (CYC_PER_SEC < 2 || SEC_PER_MIN < 1 || SEC_PER_MIN > 255) begin
      $error("cbst_tick_gen: unsupported prescale values");
    end
  end

  // Cycle prescaler; a restart begins a whole new second so the first tick is never short.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 32'h0;
      sec_tick <= 1'b0;
    end else if (ce) begin
      sec_tick <= 1'b0;
      if (restart) begin
        pre_q <= 32'h0;
      end else if (pre_q == 32'(CYC_PER_SEC - 1)) begin
        pre_q <= 32'h0;
        sec_tick <= 1'b1;
      end else begin
        pre_q <= pre_q + 32'h1;
      end
    end
  end

  // Seconds counter producing the minute tick, realigned on restart as well.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_q <= 8'h0;
      min_tick <= 1'b0;
    end else if (ce) begin
      min_tick <= 1'b0;
      if (restart) begin
        sec_q <= 8'h0;
      end else if (sec_tick) begin
        if (sec_q == 8'(SEC_PER_MIN - 1)) begin
          sec_q <= 8'h0;
          min_tick <= 1'b1;
        end else begin
          sec_q <= sec_q + 8'h1;
        end
      end
    end
  end
endmodule // cbst_tick_gen

// File: verilog/cbst_top.sv
// Cell balance output control with safety timer, lockout and reset handling, behind an APB slave.
// Assumes lockout_in is an asynchronous level from the supply monitor and presetn is the power-on reset.
`include "cbst_regs.svh"

module cbst_top #(
  parameter int CYC_PER_SEC = `CBST_CYC_PER_SEC,
  parameter int SOFT_RST_CYC = `CBST_SOFT_RST_CYC,
  parameter int LOCKOUT_CYC = `CBST_LOCKOUT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lockout_in,
  output cbst_pkg::cbst_bal_t balance_out,
  output logic irq
);
  import cbst_pkg::*;

  logic lock_meta_q, lock_sync_q;
  logic [31:0] lock_cnt_q;
  logic lock_act_q;
  logic [31:0] srst_cnt_q;
  logic srst;
  logic [7:0] bal_q, timeout_q, elapsed_q;
  logic [5:0] addr_q;
  logic lock_flag_q, por_flag_q;
  logic [2:0] irq_stat_q, irq_mask_q;
  cbst_state_t state_q;
  logic sec_tick, min_tick, unit_tick;
  logic wr_en, rd_setup, wr_bal, start, stop_clr, expire, lock_rise;
  logic [2:0] irq_set;
  logic [31:0] rd_val;

  initial begin
    if (CYC_PER_SEC < 2 || SOFT_RST_CYC < 1 || LOCKOUT_CYC < 1) begin
      $error("cbst_top: unsupported timing parameters");
    end
  end

  // Address decode shared by the write enable and the error answer.
  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      `CBST_OFF_BAL_CTRL, `CBST_OFF_TIMEOUT, `CBST_OFF_DEV_STAT, `CBST_OFF_FAULT_STAT,
      `CBST_OFF_ADDR_CTRL, `CBST_OFF_RESET, `CBST_OFF_IRQ_STAT, `CBST_OFF_IRQ_MASK: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  // The bus stalls during the shortened reset so no write is lost into a register that is being cleared.
  assign srst = (srst_cnt_q != 32'h0);
  assign pready = !srst;
  assign pslverr = psel && penable && !addr_mapped(paddr);
  assign wr_en = ce && psel && penable && pready && pwrite && addr_mapped(paddr);
  assign rd_setup = ce && psel && !penable && !pwrite;
  assign wr_bal = wr_en && (paddr == `CBST_OFF_BAL_CTRL);
  assign unit_tick = bal_q[`CBST_BAL_UNIT_BIT] ? min_tick : sec_tick;

  // Timer control terms; a start only counts when a nonzero timeout is programmed.
  assign start = wr_bal && (bal_q[5:0] == 6'h0) && (pwdata[5:0] != 6'h0) && (timeout_q != 8'h0) && !lock_act_q;
  assign stop_clr = wr_bal && (pwdata[5:0] == 6'h0);
  assign expire = (state_q == cbst_run) && ((timeout_q == 8'h0) ||
                  (unit_tick && ((elapsed_q + 8'h1) >= timeout_q)));
  assign lock_rise = ce && !lock_act_q && lock_sync_q && (lock_cnt_q == 32'(LOCKOUT_CYC - 1));

  cbst_tick_gen #(
    .CYC_PER_SEC(CYC_PER_SEC),
    .SEC_PER_MIN(`CBST_SEC_PER_MIN)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .restart(start || srst),
    .sec_tick(sec_tick),
    .min_tick(min_tick)
  );

  // Two-stage synchroniser for the asynchronous lockout level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_meta_q <= 1'b0;
      lock_sync_q <= 1'b0;
    end else if (ce) begin
      lock_meta_q <= lockout_in;
      lock_sync_q <= lock_meta_q;
    end
  end

  // Lockout filter: the level must persist for the whole filter time before balancing is cut.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt_q <= 32'h0;
      lock_act_q <= 1'b0;
    end else if (ce) begin
      if (!lock_sync_q) begin
        lock_cnt_q <= 32'h0;
        lock_act_q <= 1'b0;
      end else if (lock_rise) begin
        lock_act_q <= 1'b1;
      end else if (!lock_act_q) begin
        lock_cnt_q <= lock_cnt_q + 32'h1;
      end
    end
  end

  // Shortened reset period started by the reset code; it acts like power-on reset on all state except prdata and the lockout synchroniser and filter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srst_cnt_q <= 32'h0;
    end else if (ce) begin
      if (wr_en && paddr == `CBST_OFF_RESET && pwdata[7:0] == `CBST_RESET_CODE) begin
        srst_cnt_q <= 32'(SOFT_RST_CYC);
      end else if (srst) begin
        srst_cnt_q <= srst_cnt_q - 32'h1;
      end
    end
  end

  // Balance control: host writes, cell bits cleared on expiry and forced to zero under lockout.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bal_q <= `CBST_BAL_RST;
    end else if (ce) begin
      if (srst) begin
        bal_q <= `CBST_BAL_RST;
      end else if (lock_act_q) begin
        bal_q <= 8'h00;
      end else if (wr_bal) begin
        bal_q <= {pwdata[7], 1'b0, pwdata[5:0]};
      end else if (expire) begin
        bal_q[5:0] <= 6'h0;
      end
    end
  end

  // Timeout value; the host may rewrite it at any moment, even while the timer runs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_q <= `CBST_TIMEOUT_RST;
    end else if (ce) begin
      if (srst) begin
        timeout_q <= `CBST_TIMEOUT_RST;
      end else if (wr_en && paddr == `CBST_OFF_TIMEOUT) begin
        timeout_q <= pwdata[7:0];
      end
    end
  end

  // Safety timer state; a nonzero to nonzero write is neither start nor stop and leaves it running.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= cbst_idle;
      elapsed_q <= 8'h0;
    end else if (ce) begin
      case (state_q)
        cbst_idle: begin
          elapsed_q <= 8'h0;
          if (start) begin
            state_q <= cbst_run;
          end
        end
        cbst_run: begin
          if (srst || lock_act_q || stop_clr || expire) begin
            state_q <= cbst_idle;
            elapsed_q <= 8'h0;
          end else if (unit_tick) begin
            elapsed_q <= elapsed_q + 8'h1;
          end
        end
        default: begin
          state_q <= cbst_idle;
          elapsed_q <= 8'h0;
        end
      endcase
    end
  end

  // Outputs follow the stored bits, but only while the timer runs with a nonzero timeout.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      balance_out <= 6'h0;
    end else if (ce) begin
      if (state_q == cbst_run && !expire && !srst && !lock_act_q && timeout_q != 8'h0) begin
        balance_out <= bal_q[5:0];
      end else begin
        balance_out <= 6'h0;
      end
    end
  end

  // Device address; reads zero after any reset until the host assigns one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= 6'h0;
    end else if (ce) begin
      if (srst) begin
        addr_q <= 6'h0;
      end else if (wr_en && paddr == `CBST_OFF_ADDR_CTRL) begin
        addr_q <= pwdata[5:0];
      end
    end
  end

  // Latched lockout and power-on flags; a set in the same cycle as a clear wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_flag_q <= 1'b0;
      por_flag_q <= 1'b1;
    end else if (ce) begin
      if (srst) begin
        lock_flag_q <= 1'b0;
        por_flag_q <= 1'b1;
      end else begin
        if (lock_rise) begin
          lock_flag_q <= 1'b1;
        end else if (wr_en && paddr == `CBST_OFF_DEV_STAT && pwdata[`CBST_DEV_LOCKOUT_BIT]) begin
          lock_flag_q <= 1'b0;
        end
        if (wr_en && paddr == `CBST_OFF_FAULT_STAT && pwdata[`CBST_FAULT_POR_BIT]) begin
          por_flag_q <= 1'b0;
        end
      end
    end
  end

  // Interrupt status and mask; status bits are sticky and cleared by writing one.
  assign irq_set = {srst, lock_rise, expire};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 3'h4;
      irq_mask_q <= `CBST_MASK_RST;
    end else if (ce) begin
      if (srst) begin
        irq_stat_q <= 3'h4;
        irq_mask_q <= `CBST_MASK_RST;
      end else if (wr_en && paddr == `CBST_OFF_IRQ_MASK) begin
        irq_mask_q <= pwdata[2:0];
      end
      if (srst) begin
        irq_stat_q <= 3'h4;
      end else if (wr_en && paddr == `CBST_OFF_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~pwdata[2:0]) | irq_set;
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // Read mux; reserved bits and the write-only reset register read zero.
  always_comb begin
    rd_val = 32'h0;
    case (paddr)
      `CBST_OFF_BAL_CTRL: rd_val = {24'h0, bal_q};
      `CBST_OFF_TIMEOUT: rd_val = {24'h0, timeout_q};
      `CBST_OFF_DEV_STAT: rd_val = {29'h0,
        (addr_q >= `CBST_ADDR_MIN) && (addr_q <= `CBST_ADDR_MAX), lock_flag_q, state_q == cbst_run};
      `CBST_OFF_FAULT_STAT: rd_val = {31'h0, por_flag_q};
      `CBST_OFF_ADDR_CTRL: rd_val = {26'h0, addr_q};
      `CBST_OFF_IRQ_STAT: rd_val = {29'h0, irq_stat_q};
      `CBST_OFF_IRQ_MASK: rd_val = {29'h0, irq_mask_q};
      default: rd_val = 32'h0;
    endcase
  end

  // Read data is captured in the setup cycle so it comes from a flip-flop in the access phase.
  // A read stalled by the shortened reset keeps refreshing, so it returns the restored defaults.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_setup || (ce && psel && penable && !pwrite && !pready)) begin
      prdata <= rd_val;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_out_follow_bits: assert property (ce && state_q == cbst_run && !expire && !srst && !lock_act_q
    && timeout_q != 8'h0 |=> balance_out == $past(bal_q[5:0]))
    else $error("balance outputs do not follow control bits");
  chk_unit_select: assert property (ce && state_q == cbst_run && !bal_q[7] && sec_tick && !expire && !srst
    && !lock_act_q && !stop_clr |=> elapsed_q == $past(elapsed_q) + 8'h1)
    else $error("second unit did not advance timer");
  chk_start_timer: assert property (ce && state_q == cbst_idle && start |=> state_q == cbst_run && elapsed_q == 8'h0)
    else $error("timer did not start on zero to nonzero write");
  chk_stop_clear: assert property (ce && state_q == cbst_run && stop_clr |=> state_q == cbst_idle)
    else $error("timer kept running after clear");
  chk_no_restart: assert property (ce && state_q == cbst_run && wr_bal && bal_q[5:0] != 6'h0
    && pwdata[5:0] != 6'h0 && !expire && !unit_tick && !lock_act_q |=> elapsed_q == $past(elapsed_q))
    else $error("nonzero rewrite restarted timer");
  chk_expire_clears: assert property (ce && expire && !wr_bal |=> bal_q[5:0] == 6'h0 ##1 balance_out == 6'h0)
    else $error("expiry did not clear balance outputs");
  chk_zero_timeout: assert property (timeout_q == 8'h0 && ce |=> balance_out == 6'h0)
    else $error("outputs on with zero timeout");
  chk_active_flag: assert property (ce && rd_setup && paddr == `CBST_OFF_DEV_STAT
    |=> prdata[`CBST_DEV_TIMER_BIT] == $past(state_q == cbst_run))
    else $error("timer active flag wrong");
  chk_lockout_zero: assert property (ce && lock_rise |=> lock_flag_q && lock_act_q ##1 bal_q == 8'h00)
    else $error("lockout did not zero balance control");
  chk_soft_reset: assert property (srst && ce |=> por_flag_q && addr_q == 6'h0 && !pready || !srst)
    else $error("shortened reset did not restore defaults");
  chk_flag_sticky: assert property (ce && por_flag_q && !(wr_en && paddr == `CBST_OFF_FAULT_STAT) |=> por_flag_q)
    else $error("power-on flag dropped without a clear");

  cov_start: cover property (ce && start ##[1:20] state_q == cbst_run);
  cov_expire: cover property (ce && expire);
  cov_lockout: cover property (ce && lock_rise && state_q == cbst_run);
  cov_soft_reset: cover property (wr_en && paddr == `CBST_OFF_RESET && pwdata[7:0] == `CBST_RESET_CODE);
endmodule // cbst_top

// File: tb/cbst_gate_model.sv
// Model of the external balance transistors that the six gate outputs switch.
// Assumes one transistor per cell, on while its gate output is high.
module cbst_gate_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire cbst_pkg::cbst_bal_t gate_drive,
  output logic [5:0] fet_on,
  output int on_cycles
);
  import cbst_pkg::*;

  // A high gate level turns the transistor on; there is no gate delay in this model.
  assign fet_on = gate_drive;

  // Counts cycles with any cell bleeding, so a stuck output shows up as energy drawn.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_cycles <= 0;
    end else if (fet_on != 6'h00) begin
      on_cycles <= on_cycles + 1;
    end
  end
endmodule // cbst_gate_model

// File: tb/testbench.sv
// Self-checking bench for the balance safety timer: APB master, read-data monitor, gate model.
// Assumes short prescaler and reset counts so that a minute lasts 600 cycles.
`include "cbst_regs.svh"
module testbench;
  import cbst_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC = 10;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} cbst_exp_t;
  logic pclk, presetn, ce, psel, penable, pwrite, pslverr, pready, irq, lockout_in;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  cbst_bal_t balance_out;
  logic [5:0] fet_on, pat;
  int error_cnt = 0;
  int checks_done = 0;
  integer seed = 32'h247FD77A;
  time t0;
  time ts;
  cbst_exp_t exp_q[$];
  cbst_exp_t cur;

  cbst_top #(.CYC_PER_SEC(SEC), .SOFT_RST_CYC(4), .LOCKOUT_CYC(4)) dut_u (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lockout_in(lockout_in), .balance_out(balance_out), .irq(irq));
  cbst_gate_model gate_u (.pclk(pclk), .presetn(presetn), .gate_drive(balance_out), .fet_on(fet_on),
    .on_cycles());

  // Free-running 125 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One APB transfer; pready is sampled at the rising edge that completes the access phase.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 500);
    if (n >= 500) check("pready", pready, 1'b1);
    t0 = $time;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  // The expected word is queued before the transfer; the monitor compares it.
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = 32'hFFFFFFFF,
    input logic e = 1'b0);
    exp_q.push_back('{d: d, m: m, e: e});
    apb(a, 1'b0, 32'h00000000);
  endtask

  // Lets the register-to-output flop follow a write that took effect at the last edge.
  task automatic settle();
    @(posedge pclk);
    @(negedge pclk);
  endtask

  // Measures cycles from the starting write until the outputs drop.
  task automatic expire(input int nexp);
    int n;
    int el;
    repeat (2) @(negedge pclk);
    n = 2;
    while (balance_out !== 6'h00 && n < 5000) begin
      @(negedge pclk);
      n++;
    end
    el = int'(($time - t0 - 4) / 8);
    check("expiry_cycles", (el >= nexp - 2 && el <= nexp + 3), 1'b1);
  endtask

  // Read monitor: takes the oldest note whenever a read completes.
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0) begin
      cur = exp_q.pop_front();
      check("prdata", prdata & cur.m, cur.d);
      check("pslverr", pslverr, cur.e);
    end
  end

  // Watchdog far beyond the roughly nine hundred cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    summarize();
  end

  // Main sequence.
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    lockout_in = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`CBST_OFF_FAULT_STAT, 32'h00000001);
    rd(`CBST_OFF_ADDR_CTRL, 32'h00000000);
    rd(`CBST_OFF_DEV_STAT, 32'h00000000, 32'h00000007);
    rd(`CBST_OFF_IRQ_STAT, 32'h00000004);
    rd(`CBST_OFF_TIMEOUT, 32'h00000000);
    rd(`CBST_OFF_BAL_CTRL, 32'h00000000);
    rd(8'h20, 32'h00000000, 32'hFFFFFFFF, 1'b1);
    check("irq_masked", irq, 1'b0);
    wr(`CBST_OFF_FAULT_STAT, 32'h00000001);
    rd(`CBST_OFF_FAULT_STAT, 32'h00000000);
    wr(`CBST_OFF_IRQ_STAT, 32'h00000004);
    // A zero timeout keeps the gates off whatever the control bits say.
    wr(`CBST_OFF_BAL_CTRL, 32'h00000001);
    settle();
    check("bal_no_timeout", balance_out, 6'h00);
    wr(`CBST_OFF_BAL_CTRL, 32'h00000000);
    wr(`CBST_OFF_ADDR_CTRL, 32'h00000005);
    rd(`CBST_OFF_DEV_STAT, 32'h00000004, 32'h00000004);
    wr(`CBST_OFF_TIMEOUT, 32'h00000003);
    wr(`CBST_OFF_IRQ_MASK, 32'h00000001);
    // Random start pattern, then a nonzero change that must not restart the count.
    pat = ($random(seed) & 6'h3F) | 6'h01;
    wr(`CBST_OFF_BAL_CTRL, {26'h0, pat});
    ts = t0;
    settle();
    check("bal_follow", fet_on, pat);
    rd(`CBST_OFF_DEV_STAT, 32'h00000001, 32'h00000001);
    wr(`CBST_OFF_BAL_CTRL, {26'h0, pat ^ 6'h20});
    t0 = ts;
    settle();
    check("bal_change", balance_out, pat ^ 6'h20);
    expire(3 * SEC);
    rd(`CBST_OFF_BAL_CTRL, 32'h00000000, 32'h0000003F);
    rd(`CBST_OFF_DEV_STAT, 32'h00000000, 32'h00000001);
    check("irq_expiry", irq, 1'b1);
    wr(`CBST_OFF_IRQ_STAT, 32'h00000001);
    settle();
    check("irq_cleared", irq, 1'b0);
    // Clearing all bits stops the timer; a fresh zero-to-nonzero write restarts the full period.
    wr(`CBST_OFF_BAL_CTRL, 32'h00000001);
    repeat (15) @(posedge pclk);
    wr(`CBST_OFF_BAL_CTRL, 32'h00000000);
    rd(`CBST_OFF_DEV_STAT, 32'h00000000, 32'h00000001);
    wr(`CBST_OFF_BAL_CTRL, 32'h00000002);
    expire(3 * SEC);
    // Minute unit with a one-unit timeout.
    wr(`CBST_OFF_TIMEOUT, 32'h00000001);
    wr(`CBST_OFF_BAL_CTRL, 32'h00000081);
    expire(60 * SEC);
    // Sustained lockout zeroes the control register but keeps other registers and the bus alive.
    wr(`CBST_OFF_TIMEOUT, 32'h00000032);
    wr(`CBST_OFF_BAL_CTRL, 32'h0000003F);
    @(posedge pclk);
    lockout_in <= 1'b1;
    repeat (12) @(posedge pclk);
    rd(`CBST_OFF_BAL_CTRL, 32'h00000000, 32'h0000003F);
    rd(`CBST_OFF_DEV_STAT, 32'h00000002, 32'h00000003);
    rd(`CBST_OFF_TIMEOUT, 32'h00000032);
    wr(`CBST_OFF_BAL_CTRL, 32'h00000001);
    settle();
    check("bal_lockout", balance_out, 6'h00);
    lockout_in <= 1'b0;
    repeat (12) @(posedge pclk);
    rd(`CBST_OFF_DEV_STAT, 32'h00000002, 32'h00000002);
    wr(`CBST_OFF_DEV_STAT, 32'h00000002);
    rd(`CBST_OFF_DEV_STAT, 32'h00000000, 32'h00000002);
    // Reset command while balancing: everything returns to defaults after the short stall.
    wr(`CBST_OFF_BAL_CTRL, 32'h00000003);
    wr(`CBST_OFF_RESET, {24'h0, `CBST_RESET_CODE});
    rd(`CBST_OFF_FAULT_STAT, 32'h00000001);
    rd(`CBST_OFF_ADDR_CTRL, 32'h00000000);
    rd(`CBST_OFF_TIMEOUT, 32'h00000000);
    rd(`CBST_OFF_BAL_CTRL, 32'h00000000);
    rd(`CBST_OFF_IRQ_STAT, 32'h00000004);
    check("bal_soft_reset", balance_out, 6'h00);
    repeat (2) @(posedge pclk);
    summarize();
  end
endmodule // testbench
